// ==== dsp_core_ctrl.sv ====
`timescale 1ns/1ns
`include "dsp_core_ctrl_regs.svh"
// Core control register bank with safeload engine.
module dsp_core_ctrl
  import dsp_core_ctrl_pkg::*;
#(
  parameter int NUM_SL = 5,
  parameter int AW     = 10,
  parameter int DW     = 28
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  // Control port
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  input  wire logic [11:0]   addr_i,
  input  wire logic [15:0]   wdata_i,
  output logic      [15:0]   rdata_o,
  // DSP program side
  input  wire logic          prog_if_we_i,
  input  wire logic [2:0]    prog_if_idx_i,
  input  wire logic [15:0]   prog_if_data_i,
  input  wire logic [15:0]   gpio_pins_i,
  // Parameter RAM write port
  output logic               pram_we_o,
  output logic      [AW-1:0] pram_addr_o,
  output logic      [DW-1:0] pram_data_o,
  // Core controls
  output logic      [15:0]   gpio_setting_o,
  output logic               adc_mute_n_o,
  output logic               dac_mute_n_o,
  output logic               core_regs_clear_n_o,
  output logic      [10:0]   instr_per_sample_o,
  output logic      [7:0]    conv_rate_khz_o
);
  // The slot map holds five pairs; more slots would run into the address range.
  if (NUM_SL != 5) begin : g_bad_slots
    $error("dsp_core_ctrl: five safeload slots expected");
  end

  // ****************************************
  // Register state
  // ****************************************
  // Eight interface words, indexed by the low address bits.
  logic [15:0]       core_ctrl;
  logic [15:0]       if_regs [0:7];
  logic [2:0]        sl_idx;
  logic [NUM_SL-1:0] pend;
  logic [NUM_SL-1:0] taken;
  logic [AW-1:0]     sl_addr [NUM_SL];
  logic [DW-1:0]     sl_data [NUM_SL];
  sl_state_t         state;

  // Field views of the control register.
  wire       gpio_setting_host_write  = core_ctrl[`CC_GPIO_HOST_WR];
  wire       interface_regs_host_write = core_ctrl[`CC_IF_HOST_WR];
  wire       safeload_trigger         = core_ctrl[`CC_SL_TRIGGER];
  wire [1:0] rate_select              = core_ctrl[`CC_RATE_LO +: 2];

  // Address decode.
  wire cc_we   = wr_i && addr_i == `ADDR_CORE_CTRL;
  wire gpio_we = wr_i && addr_i == `ADDR_GPIO_SET && gpio_setting_host_write;
  wire if_hit  = addr_i >= `ADDR_IF_FIRST && addr_i <= `ADDR_IF_LAST;
  wire if_we   = wr_i && if_hit && interface_regs_host_write;
  wire [2:0] if_idx = addr_i[2:0];
  // Trigger set holds off the trigger clear in the control register; busy is what other reads return.
  wire trig_set = cc_we && wdata_i[`CC_SL_TRIGGER];
  wire busy     = state != SL_IDLE;

  // ****************************************
  // Safeload slots
  // ****************************************
  // Each slot owns an address and a data register.
  for (genvar g = 0; g < NUM_SL; g++) begin : g_sl
    // Slot n answers at the n-th data word and the n-th address word.
    wire addr_hit = wr_i && addr_i == `ADDR_SL_ADDR0 + 12'(g);
    wire data_hit = wr_i && addr_i == `ADDR_SL_DATA0 + 12'(g);
    safeload_entry #(.AW(AW), .DW(DW)) u_entry (
      .clk_i     (clk_i),
      .resetn_i  (resetn_i),
      .addr_we_i (addr_hit),
      .data_we_i (data_hit),
      .wdata_i   (wdata_i),
      .taken_i   (taken[g]),
      .addr_o    (sl_addr[g]),
      .data_o    (sl_data[g]),
      .pending_o (pend[g])
    );
    assign taken[g] = state == SL_SCAN && sl_idx == 3'(g);
  end

  // ****************************************
  // Control register
  // ****************************************
  // Trigger bit: host may only set it; engine clears it at the end.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_ctrl <= `CC_RESET;
    end else begin
      if (cc_we) begin
        core_ctrl <= (wdata_i & `CC_WR_MASK) | (16'(safeload_trigger) << `CC_SL_TRIGGER);
      end
      // A trigger write in the done cycle restarts the engine instead of being lost.
      if (state == SL_DONE && !trig_set) begin
        core_ctrl[`CC_SL_TRIGGER] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Safeload engine
  // ****************************************
  // One slot per cycle; only pending slots produce a RAM write.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state       <= SL_IDLE;
      sl_idx      <= 3'h0;
      pram_we_o   <= 1'b0;
      pram_addr_o <= '0;
      pram_data_o <= '0;
    end else begin
      pram_we_o <= 1'b0;
      case (state)
        SL_IDLE: begin
          sl_idx <= 3'h0;
          if (safeload_trigger) begin
            state <= SL_SCAN;
          end
        end
        SL_SCAN: begin
          pram_we_o   <= pend[sl_idx];
          pram_addr_o <= sl_addr[sl_idx];
          pram_data_o <= sl_data[sl_idx];
          if (sl_idx == 3'(NUM_SL - 1)) begin
            state <= SL_DONE;
          end
          // The index runs one past the last slot; idle sets it back.
          sl_idx <= sl_idx + 3'h1;
        end
        // One spare cycle lets the trigger clear before idle looks at it again.
        SL_DONE: state <= SL_IDLE;
        default: state <= SL_IDLE;
      endcase
    end
  end

  // ****************************************
  // Interface and GPIO registers
  // ****************************************
  // Host write mode locks out the program so host values persist.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 8; i++) begin
        if_regs[i] <= 16'h0000;
      end
      gpio_setting_o <= 16'h0000;
    end else begin
      // A host write wins over a program write in the same cycle.
      if (if_we) begin
        if_regs[if_idx] <= wdata_i;
      end else if (prog_if_we_i && !interface_regs_host_write) begin
        if_regs[prog_if_idx_i] <= prog_if_data_i;
      end
      if (gpio_we) begin
        gpio_setting_o <= wdata_i;
      end else if (!gpio_setting_host_write) begin
        gpio_setting_o <= gpio_pins_i;
      end
    end
  end

  // ****************************************
  // Core outputs
  // ****************************************
  // Reserved rate code falls back to single rate.
  // Every control pin is a flop, so it lags the control word by one cycle.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      adc_mute_n_o        <= 1'b0;
      dac_mute_n_o        <= 1'b0;
      core_regs_clear_n_o <= 1'b0;
      instr_per_sample_o  <= `INSTR_1X;
      conv_rate_khz_o     <= `FS_KHZ_1X;
    end else begin
      adc_mute_n_o        <= core_ctrl[`CC_ADC_MUTE_N];
      dac_mute_n_o        <= core_ctrl[`CC_DAC_MUTE_N];
      core_regs_clear_n_o <= core_ctrl[`CC_CLEAR_N];
      case (rate_select)
        `RATE_2X: begin
          instr_per_sample_o <= `INSTR_2X;
          conv_rate_khz_o    <= `FS_KHZ_2X;
        end
        `RATE_4X: begin
          instr_per_sample_o <= `INSTR_4X;
          conv_rate_khz_o    <= `FS_KHZ_4X;
        end
        default: begin
          instr_per_sample_o <= `INSTR_1X;
          conv_rate_khz_o    <= `FS_KHZ_1X;
        end
      endcase
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Other addresses report whether a safeload transfer is still running.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      if (addr_i == `ADDR_CORE_CTRL) begin
        rdata_o <= core_ctrl;
      end else if (if_hit) begin
        rdata_o <= if_regs[if_idx];
      end else if (addr_i == `ADDR_GPIO_SET) begin
        rdata_o <= gpio_setting_o;
      end else begin
        rdata_o <= {15'h0000, busy};
      end
    end
  end
endmodule

// ==== dsp_core_ctrl_regs.svh ====
// Functional notes
// - Host may write GPIO setting while enabled
// - GPIO setting ignores pins while host-write set
// - Host writes interface registers while enabled
// - Program cannot update interface registers then
// - Writing trigger one starts safeload transfer
// - Trigger clears itself when transfer completes
// - Five safeload address/data entry pairs
// - Only entries written since last event move
// - ADC mute active low, resets muted
// - DAC mute active low, resets muted
// - Core clear active low, resets cleared
// - Rate field: 1024, 512, 256 instructions
// - Double rate runs converters at 96 kHz
// - Quadruple rate runs converters at 192 kHz
`ifndef DSP_CORE_CTRL_REGS_SVH
`define DSP_CORE_CTRL_REGS_SVH

// ****************************************
// Register addresses
// ****************************************
`define ADDR_IF_FIRST     12'h800
`define ADDR_IF_LAST      12'h807
`define ADDR_GPIO_SET     12'h808
`define ADDR_SL_DATA0     12'h810
`define ADDR_SL_ADDR0     12'h815
`define ADDR_CORE_CTRL    12'h81c

// ****************************************
// Control register fields
// ****************************************
`define CC_RATE_LO        0
`define CC_CLEAR_N        2
`define CC_DAC_MUTE_N     3
`define CC_ADC_MUTE_N     4
`define CC_SL_TRIGGER     5
`define CC_IF_HOST_WR     6
`define CC_GPIO_HOST_WR   7
`define CC_RESET          16'h0000
`define CC_WR_MASK        16'h00ff

// ****************************************
// Rate codes and results
// ****************************************
`define RATE_1X           2'h0
`define RATE_2X           2'h1
`define RATE_4X           2'h2
`define INSTR_1X          11'h400
`define INSTR_2X          11'h200
`define INSTR_4X          11'h100
`define FS_KHZ_1X         8'h30
`define FS_KHZ_2X         8'h60
`define FS_KHZ_4X         8'hc0

`endif

// ==== dsp_core_ctrl_pkg.sv ====
package dsp_core_ctrl_pkg;
  typedef enum logic [1:0] {
    SL_IDLE = 2'h0,
    SL_SCAN = 2'h1,
    SL_DONE = 2'h3
  } sl_state_t;
endpackage

// ==== safeload_entry.sv ====
`timescale 1ns/1ns
// One safeload slot: address/data pair and its written-since-last-event flag.
module safeload_entry #(
  parameter int AW = 10,
  parameter int DW = 28
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  // Host side
  input  wire logic          addr_we_i,
  input  wire logic          data_we_i,
  input  wire logic [15:0]   wdata_i,
  // Transfer side
  input  wire logic          taken_i,
  output logic      [AW-1:0] addr_o,
  output logic      [DW-1:0] data_o,
  output logic               pending_o
);
  // Data must be wider than one host word, or the shift below has no lower part to keep.
  if (AW < 1 || AW > 16 || DW < 17 || DW > 32) begin : g_bad_widths
    $error("safeload_entry: bad widths");
  end

  // Data words arrive 16 bits per write; earlier bits shift up into the upper part.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_o    <= '0;
      data_o    <= '0;
      pending_o <= 1'b0;
    end else begin
      if (addr_we_i) begin
        addr_o <= wdata_i[AW-1:0];
      end
      if (data_we_i) begin
        data_o <= {data_o[DW-17:0], wdata_i};
      end
      // A new write in the same cycle as the take keeps the slot pending.
      if (addr_we_i || data_we_i) begin
        pending_o <= 1'b1;
      end else if (taken_i) begin
        pending_o <= 1'b0;
      end
    end
  end
endmodule

// ==== dsp_core_ctrl_asserts.sv ====
`timescale 1ns/1ns
`include "dsp_core_ctrl_regs.svh"
// Port-level checks of the control register bank.
module dsp_core_ctrl_asserts (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        resetn_i,
  // Control port
  input wire logic        wr_i,
  input wire logic [11:0] addr_i,
  input wire logic [15:0] wdata_i,
  // Outputs
  input wire logic [15:0] gpio_setting_o,
  input wire logic        adc_mute_n_o,
  input wire logic        dac_mute_n_o,
  input wire logic        core_regs_clear_n_o,
  input wire logic [10:0] instr_per_sample_o,
  input wire logic [7:0]  conv_rate_khz_o,
  input wire logic        pram_we_o
);
  logic       ctl_wr;
  logic       gpio_host;
  logic [3:0] sl_age;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // A write to the core control word.
  assign ctl_wr = wr_i && addr_i == `ADDR_CORE_CTRL;
  // Shadow of the GPIO host-write bit; age saturates so old triggers never count.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gpio_host <= 1'b0;
      sl_age    <= 4'hf;
    end else begin
      if (ctl_wr) gpio_host <= wdata_i[`CC_GPIO_HOST_WR];
      if (ctl_wr && wdata_i[`CC_SL_TRIGGER]) sl_age <= 4'h0;
      else if (sl_age != 4'hf) sl_age <= sl_age + 4'h1;
    end
  end
  // Control pins settle two edges after the write: control word, then output flop.
  sequence ctl_settled;
    ctl_wr ##2 1'b1;
  endsequence
  AST_ADC_MUTE: assert property (ctl_settled |->
    adc_mute_n_o == $past(wdata_i[`CC_ADC_MUTE_N], 2)) else $error("adc mute wrong");
  AST_DAC_MUTE: assert property (ctl_settled |->
    dac_mute_n_o == $past(wdata_i[`CC_DAC_MUTE_N], 2)) else $error("dac mute wrong");
  AST_CLEAR: assert property (ctl_settled |->
    core_regs_clear_n_o == $past(wdata_i[`CC_CLEAR_N], 2)) else $error("core clear wrong");
  AST_RATE_DOUBLE: assert property (ctl_wr && wdata_i[1:0] == `RATE_2X |=> ##1
    instr_per_sample_o == `INSTR_2X && conv_rate_khz_o == `FS_KHZ_2X) else $error("2x wrong");
  AST_RATE_QUAD: assert property (ctl_wr && wdata_i[1:0] == `RATE_4X |=> ##1
    instr_per_sample_o == `INSTR_4X && conv_rate_khz_o == `FS_KHZ_4X) else $error("4x wrong");
  AST_GPIO_WRITE: assert property (gpio_host && wr_i && addr_i == `ADDR_GPIO_SET |=>
    gpio_setting_o == $past(wdata_i)) else $error("gpio write lost");
  AST_GPIO_HOLD: assert property (gpio_host && !wr_i |=> $stable(gpio_setting_o))
    else $error("gpio setting moved");
  AST_SL_WINDOW: assert property (pram_we_o |-> sl_age <= 4'h8)
    else $error("stray parameter write");
  AST_RESET_STATE: assert property ($rose(resetn_i) |-> !adc_mute_n_o && !dac_mute_n_o
    && !core_regs_clear_n_o && instr_per_sample_o == `INSTR_1X) else $error("reset state");
endmodule

// ==== host_model.sv ====
`timescale 1ns/1ns
// Control port master standing in for the host controller.
module host_model (
  // Clock
  input  wire logic        clk_i,
  // Control port
  output logic             wr_o,
  output logic             rd_o,
  output logic [11:0]      addr_o,
  output logic [15:0]      wdata_o,
  input  wire logic [15:0] rdata_i
);
  // Idle port at time zero.
  initial begin
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    addr_o  = 12'h000;
    wdata_o = 16'h0000;
  end
  // One word write; data is scrambled after release so stale values never help.
  task automatic write(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_o    <= 1'b1;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask
  // Read data is registered, so it is taken one edge after the strobe.
  task automatic read(input logic [11:0] a, output logic [15:0] d);
    @(posedge clk_i);
    rd_o   <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule

// ==== dsp_core_control_bits_bench.sv ====
`timescale 1ns/1ns
`include "dsp_core_ctrl_regs.svh"
`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module dsp_core_control_bits_bench;
  logic        clk_i = 1'b0, resetn_i = 1'b0, wr, rd, pwe, adc_n, dac_n, clr_n, prog_we;
  logic [11:0] addr;
  logic [15:0] wdata, rdata, pins, gpio, prog_data, v;
  logic [2:0]  prog_idx;
  logic [9:0]  paddr;
  logic [27:0] pdata;
  logic [10:0] instr;
  logic [7:0]  khz;
  int          miscompares = 0, comparisons = 0, cycles = 0;
  logic [9:0]  pw_a [$];
  logic [27:0] pw_d [$];
  host_model i_host_model (.clk_i, .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata),
    .rdata_i(rdata));
  dsp_core_ctrl i_dsp_core_ctrl (.clk_i, .resetn_i, .wr_i(wr), .rd_i(rd), .addr_i(addr),
    .wdata_i(wdata), .rdata_o(rdata), .prog_if_we_i(prog_we), .prog_if_idx_i(prog_idx),
    .prog_if_data_i(prog_data), .gpio_pins_i(pins), .pram_we_o(pwe), .pram_addr_o(paddr),
    .pram_data_o(pdata), .gpio_setting_o(gpio), .adc_mute_n_o(adc_n), .dac_mute_n_o(dac_n),
    .core_regs_clear_n_o(clr_n), .instr_per_sample_o(instr), .conv_rate_khz_o(khz));
  // Clock.
  always #20 clk_i = ~clk_i;
  // Cycle ceiling and log of parameter RAM writes.
  always @(posedge clk_i) begin
    cycles++;
    if (pwe === 1'b1) begin
      pw_a.push_back(paddr);
      pw_d.push_back(pdata);
    end
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  // Verdict and end of run.
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Program-side write to one interface register.
  task automatic prog_write(input logic [2:0] i, input logic [15:0] d);
    @(posedge clk_i);
    prog_we   <= 1'b1;
    prog_idx  <= i;
    prog_data <= d;
    @(posedge clk_i);
    prog_we   <= 1'b0;
  endtask
  // Fills one safeload slot, high data word first.
  task automatic sl_load(input logic [11:0] s, input logic [15:0] hi, lo, a);
    i_host_model.write(`ADDR_SL_DATA0 + s, hi);
    i_host_model.write(`ADDR_SL_DATA0 + s, lo);
    i_host_model.write(`ADDR_SL_ADDR0 + s, a);
  endtask
  // Test sequence: reset, rates, GPIO, interface, safeload.
  initial begin
    prog_we   = 1'b0;
    prog_idx  = 3'h0;
    prog_data = 16'h0000;
    pins      = 16'h1234;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    `CHECK({adc_n, dac_n, clr_n}, 3'h0)
    i_host_model.read(`ADDR_CORE_CTRL, v);
    `CHECK(v, `CC_RESET)
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      i_host_model.write(`ADDR_CORE_CTRL, 16'h001c | 16'(c));
      repeat (2) @(posedge clk_i);
      `CHECK(instr, c == 1 ? `INSTR_2X : c == 2 ? `INSTR_4X : `INSTR_1X)
      `CHECK(khz, c == 1 ? `FS_KHZ_2X : c == 2 ? `FS_KHZ_4X : `FS_KHZ_1X)
      `CHECK({adc_n, dac_n, clr_n}, 3'h7)
    end
    $display("test rate done");
    i_host_model.write(`ADDR_GPIO_SET, 16'hbeef);
    `CHECK(gpio, 16'h1234)
    i_host_model.write(`ADDR_CORE_CTRL, 16'h009c);
    i_host_model.write(`ADDR_GPIO_SET, 16'hbeef);
    pins <= 16'h5678;
    repeat (3) @(posedge clk_i);
    `CHECK(gpio, 16'hbeef)
    $display("test gpio done");
    prog_write(3'h7, 16'h1111);
    i_host_model.write(`ADDR_IF_LAST, 16'h2222);
    i_host_model.read(`ADDR_IF_LAST, v);
    `CHECK(v, 16'h1111)
    i_host_model.write(`ADDR_CORE_CTRL, 16'h005c);
    i_host_model.write(`ADDR_IF_LAST, 16'h3333);
    prog_write(3'h7, 16'h4444);
    i_host_model.read(`ADDR_IF_LAST, v);
    `CHECK(v, 16'h3333)
    $display("test interface done");
    sl_load(12'h1, 16'h0abc, 16'hdef0, 16'h0123);
    sl_load(12'h4, 16'h0fed, 16'hcba9, 16'h03ff);
    i_host_model.write(`ADDR_CORE_CTRL, 16'h007c);
    i_host_model.write(`ADDR_CORE_CTRL, 16'h005c);
    i_host_model.read(`ADDR_CORE_CTRL, v);
    `CHECK(v, 16'h007c)
    v = 16'h0020;
    for (int i = 0; i < 20 && v[5] !== 1'b0; i++) i_host_model.read(`ADDR_CORE_CTRL, v);
    `CHECK(v, 16'h005c)
    `CHECK({pw_a.size(), pw_a[0], pw_a[1]}, {32'd2, 10'h123, 10'h3ff})
    `CHECK({pw_d[0], pw_d[1]}, {28'habcdef0, 28'hfedcba9})
    pw_a.delete();
    i_host_model.write(`ADDR_CORE_CTRL, 16'h007c);
    i_host_model.read(`ADDR_SL_DATA0, v);
    `CHECK(v, 16'h0001)
    repeat (12) @(posedge clk_i);
    `CHECK(pw_a.size(), 0)
    $display("test safeload done");
    stop_test();
  end
endmodule
bind dsp_core_ctrl dsp_core_ctrl_asserts i_asserts (.clk_i, .resetn_i, .wr_i, .addr_i,
  .wdata_i, .gpio_setting_o, .adc_mute_n_o, .dac_mute_n_o, .core_regs_clear_n_o,
  .instr_per_sample_o, .conv_rate_khz_o, .pram_we_o);
